// >>> core/sem_defines.svh
`ifndef SEM_DEFINES_SVH
`define SEM_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SEM_OFF_CTRL 4'h0
`define SEM_OFF_OSRC 4'h4
`define SEM_OFF_RATE 4'h8
`define SEM_OFF_STAT 4'hc
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SEM_RATE_ATT_LSB 0
`define SEM_RATE_DEC_LSB 8
`define SEM_STAT_AMP_LSB 8
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SEM_CTRL_RST 32'h0000_0000
`define SEM_OSRC_RST 16'h03e8
`define SEM_RATE_RST 16'h0404
// ----------------------------------------
// Timing
// ----------------------------------------
`define SEM_CLK_NS 10
`define SEM_TICK_NS 1000
`define SEM_TICK_CYC ((`SEM_TICK_NS + `SEM_CLK_NS - 1) / `SEM_CLK_NS)
`define SEM_REARM_US 50
`define SEM_OS_NUM 4
`define SEM_OS_DEN 5
`endif

// >>> core/sem_pkg.sv
package sem_pkg;
    typedef enum logic [1:0] {
        sem_env_cont    = 2'b00,
        sem_env_oneshot = 2'b01,
        sem_env_cont_b  = 2'b10,
        sem_env_cont_c  = 2'b11
    } sem_env_e;

    typedef struct packed {
        logic [25:0] rsvd;
        logic [2:0]  mix_sel;
        logic        mix_src;
        sem_env_e    env;
    } sem_ctrl_s;

    typedef struct packed {
        logic vco;
        logic sweep_oscillator;
        logic noise;
    } sem_tone_s;

    typedef struct packed {
        logic       en_n;
        logic       en_n_drv;
        logic [2:0] mix;
        logic [2:0] mix_drv;
        logic       os_stop;
    } sem_pins_s;
endpackage

// >>> core/sem_mixer.sv
`timescale 1ns/100ps
module sem_mixer (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire sem_pkg::sem_tone_s tones,
    input  wire logic [2:0]        sel,
    output logic                   mix_out
);
    import sem_pkg::*;

    logic next_mix;

    // Selected sources are ANDed, never summed
    always_comb begin
        case (sel)
            3'h0: next_mix = tones.vco;                              // RULE13
            3'h1: next_mix = tones.sweep_oscillator;                 // RULE13
            3'h2: next_mix = tones.noise;                            // RULE13
            3'h3: next_mix = tones.vco & tones.noise;                // RULE14
            3'h4: next_mix = tones.sweep_oscillator & tones.noise;   // RULE14
            3'h5: next_mix = tones.vco & tones.sweep_oscillator
                             & tones.noise;                          // RULE14
            3'h6: next_mix = tones.sweep_oscillator & tones.vco;     // RULE14
            default: next_mix = 1'b0;                                // RULE13
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mix_out <= 1'b0;
        end else begin
            mix_out <= next_mix;
        end
    end

    a_mix_all_and: assert property (@(posedge sys_clk) disable iff (rst)
        sel == 3'h5 |=> mix_out == ($past(tones.vco) & $past(tones.noise)
            & $past(tones.sweep_oscillator))) // RULE14
        else $error("mixer three-way AND wrong");
    a_mix_inhibit: assert property (@(posedge sys_clk) disable iff (rst)
        sel == 3'h7 |=> !mix_out) // RULE13
        else $error("mixer not inhibited");
endmodule // sem_mixer

// >>> core/sem_envelope.sv
`timescale 1ns/100ps
module sem_envelope #(
    parameter int AMP_W = 8,
    parameter int DIV_W = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic             gate,
    input  wire logic             kill,
    input  wire logic [DIV_W-1:0] att_div,
    input  wire logic [DIV_W-1:0] dec_div,
    output logic      [AMP_W-1:0] amp
);
    import sem_pkg::*;

    localparam logic [AMP_W-1:0] AMP_MAX = '1;

    logic [DIV_W-1:0] step_cnt;
    logic             step;

    assign step = tick && (step_cnt >= (gate ? att_div : dec_div));

    // ----------------------------------------
    // Step pacing
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst || kill || step) begin
            step_cnt <= '0;
        end else if (tick) begin
            step_cnt <= step_cnt + 1'b1;
        end
    end

    // ----------------------------------------
    // Amplitude ramp
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst || kill) begin
            amp <= '0; // RULE16
        end else if (step && gate && amp != AMP_MAX) begin
            amp <= amp + 1'b1; // RULE22
        end else if (step && !gate && amp != '0) begin
            amp <= amp - 1'b1; // RULE17
        end
    end
endmodule // sem_envelope

// >>> core/sem_top.sv
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "sem_defines.svh"
// Overview of operation
// [RULE1] Enable high inhibits output, low passes
// [RULE2] Continuous mode sounds while enable low
// [RULE3] Undriven enable reads as zero
// [RULE4] Envelope select picks continuous or one-shot
// [RULE5] Enable falling edge sets latch, starts timer
// [RULE6] One-shot ends at expiry or enable high
// [RULE7] Expiry clears latch, next edge refires
// [RULE8] Held-low enable never retriggers
// [RULE9] Abort keeps latch until interval ends
// [RULE10] Controller pulses enable high 50 us
// [RULE11] Latch clears at timer terminal value
// [RULE12] Duration programmable, 0.8 times RC
// [RULE13] Select CBA picks sources or inhibit
// [RULE14] Multiple sources are logically ANDed
// [RULE15] Unconnected select bits read zero
// [RULE16] Enable high forces envelope to zero
// [RULE17] Sound end starts decay ramp down
// [RULE18] Outside mux toggles select 20-100 kHz
// [RULE19] Timing control rising edge ends one-shot
// [RULE20] Attack inside one-shot, decay appended
// [RULE21] One clock, synchronised enable, cycle timer
// [RULE22] Digital envelope scales mixer bit
module sem_top #(
    parameter int AMP_W    = 8,
    parameter int RC_W     = 16,
    parameter int TICK_CYC = `SEM_TICK_CYC
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic [3:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire sem_pkg::sem_pins_s pins,
    input  wire sem_pkg::sem_tone_s tones,
    output logic      [AMP_W-1:0]   sound_sample,
    output logic                    sound_active,
    output logic                    oneshot_latched
);
    import sem_pkg::*;

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (AMP_W < 2 || AMP_W > 8 || RC_W < 4 || RC_W > 16 ||
        TICK_CYC < 1) begin : g_bad_param
        $error("sem_top parameter out of range");
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    sem_ctrl_s   ctrl;
    logic [15:0] osrc;
    logic [15:0] rate;

    logic        wr_ok;
    logic        rd_ok;
    logic [31:0] next_rdata;

    assign wr_ok = avs_write && !avs_waitrequest;
    assign rd_ok = avs_read && avs_waitrequest;

    // Waitrequest drops for one cycle per request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl <= `SEM_CTRL_RST;
        end else if (wr_ok && avs_address == `SEM_OFF_CTRL) begin
            if (avs_byteenable[0]) begin
                ctrl[7:0] <= avs_writedata[7:0]; // RULE4
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            osrc <= `SEM_OSRC_RST;
        end else if (wr_ok && avs_address == `SEM_OFF_OSRC) begin
            if (avs_byteenable[0]) begin
                osrc[7:0] <= avs_writedata[7:0]; // RULE12
            end
            if (avs_byteenable[1]) begin
                osrc[15:8] <= avs_writedata[15:8]; // RULE12
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rate <= `SEM_RATE_RST;
        end else if (wr_ok && avs_address == `SEM_OFF_RATE) begin
            if (avs_byteenable[0]) begin
                rate[7:0] <= avs_writedata[7:0]; // RULE22
            end
            if (avs_byteenable[1]) begin
                rate[15:8] <= avs_writedata[15:8]; // RULE22
            end
        end
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [2:0] en_sync;
    logic [2:0] stop_sync;
    logic [2:0] mix_pin;
    logic       en_lvl;
    logic       fall;
    logic       stop_rise;

    // Open enable pin is pulled low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_sync <= 3'h0;
        end else begin
            en_sync <= {en_sync[1:0], pins.en_n & pins.en_n_drv}; // RULE3
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stop_sync <= 3'h0;
        end else begin
            stop_sync <= {stop_sync[1:0], pins.os_stop};
        end
    end

    assign en_lvl    = en_sync[1];
    assign fall      = en_sync[2] && !en_sync[1]; // RULE21
    assign stop_rise = stop_sync[1] && !stop_sync[2]; // RULE19

    // Open select pins are pulled low
    for (genvar i = 0; i < 3; i++) begin : g_mix_pull
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                mix_pin[i] <= 1'b0;
            end else begin
                mix_pin[i] <= pins.mix[i] & pins.mix_drv[i]; // RULE15
            end
        end
    end

    // ----------------------------------------
    // Timebase
    // ----------------------------------------
    localparam int TDW = $clog2(TICK_CYC + 1);
    logic [TDW-1:0] tick_cnt;
    logic           tick;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == TDW'(TICK_CYC - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    // ----------------------------------------
    // One-shot latch and timer
    // ----------------------------------------
    logic            oneshot_mode;
    logic [RC_W+2:0] os_prod;
    logic [RC_W-1:0] os_len;
    logic [RC_W-1:0] os_cnt;
    logic            fire;
    logic            expire;

    assign oneshot_mode = ctrl.env == sem_env_oneshot; // RULE4
    // Length is 0.8 x RC, at least one tick
    assign os_prod = (RC_W+3)'(osrc[RC_W-1:0]) * (RC_W+3)'(`SEM_OS_NUM)
                     / (RC_W+3)'(`SEM_OS_DEN); // RULE12
    assign os_len  = (os_prod == '0) ? RC_W'(1) : os_prod[RC_W-1:0];
    assign fire    = oneshot_mode && fall && !oneshot_latched; // RULE5 RULE8
    assign expire  = oneshot_latched && tick && os_cnt <= RC_W'(1); // RULE11

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oneshot_latched <= 1'b0;
        end else if (fire) begin
            oneshot_latched <= 1'b1; // RULE5
        end else if (expire || stop_rise) begin
            oneshot_latched <= 1'b0; // RULE7 RULE11 RULE19
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            os_cnt <= '0;
        end else if (fire) begin
            os_cnt <= os_len; // RULE21
        end else if (oneshot_latched && tick && os_cnt != '0) begin
            os_cnt <= os_cnt - 1'b1; // RULE9
        end
    end

    // ----------------------------------------
    // Sound gating
    // ----------------------------------------
    logic gate;
    logic mix_bit;
    logic [AMP_W-1:0] amp;
    logic [2:0] mix_sel;

    assign mix_sel = ctrl.mix_src ? ctrl.mix_sel : mix_pin;
    // Sound stands while enable low and mode allows
    assign gate = !en_lvl && (!oneshot_mode || oneshot_latched); // RULE2 RULE6

    sem_mixer u_mixer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tones   (tones),
        .sel     (mix_sel),
        .mix_out (mix_bit)
    );

    sem_envelope #(
        .AMP_W (AMP_W),
        .DIV_W (8)
    ) u_env (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (tick),
        .gate    (gate), // RULE20
        .kill    (en_lvl), // RULE16
        .att_div (rate[`SEM_RATE_ATT_LSB +: 8]),
        .dec_div (rate[`SEM_RATE_DEC_LSB +: 8]),
        .amp     (amp)
    );

    always_ff @(posedge sys_clk) begin
        if (rst || en_lvl) begin
            sound_sample <= '0; // RULE1
        end else begin
            sound_sample <= mix_bit ? amp : '0; // RULE22
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sound_active <= 1'b0;
        end else begin
            sound_active <= gate || (!en_lvl && amp != '0); // RULE17
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        next_rdata = 32'h0;
        if (avs_address == `SEM_OFF_CTRL) begin
            next_rdata = {24'h0, ctrl[7:0]};
        end else if (avs_address == `SEM_OFF_OSRC) begin
            next_rdata = {16'h0, osrc};
        end else if (avs_address == `SEM_OFF_RATE) begin
            next_rdata = {16'h0, rate};
        end else if (avs_address == `SEM_OFF_STAT) begin
            next_rdata = {16'h0, 8'(amp), 4'h0, mix_bit, en_lvl,
                          gate, oneshot_latched};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (rd_ok) begin
            avs_readdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_inhibit_out: assert property (@(posedge sys_clk) disable iff (rst)
        en_lvl |=> sound_sample == '0) // RULE1
        else $error("output not inhibited by enable");
    a_cont_sound: assert property (@(posedge sys_clk) disable iff (rst)
        !oneshot_mode && !en_lvl |=> sound_active) // RULE2
        else $error("continuous sound missing");
    a_edge_fires: assert property (@(posedge sys_clk) disable iff (rst)
        oneshot_mode && fall && !oneshot_latched |=> oneshot_latched
        && os_cnt == $past(os_len)) // RULE5
        else $error("falling edge did not fire one-shot");
    a_latch_holds: assert property (@(posedge sys_clk) disable iff (rst)
        oneshot_latched && !expire && !stop_rise |=> oneshot_latched) // RULE9
        else $error("latch dropped before interval end");
    a_expire_clear: assert property (@(posedge sys_clk) disable iff (rst)
        expire && !fire |=> !oneshot_latched) // RULE11
        else $error("latch not cleared at expiry");
    a_no_retrig: assert property (@(posedge sys_clk) disable iff (rst)
        !oneshot_latched && !fall |=> !oneshot_latched) // RULE8
        else $error("one-shot fired without edge");
    a_stop_ends: assert property (@(posedge sys_clk) disable iff (rst)
        stop_rise && !fire |=> !oneshot_latched) // RULE19
        else $error("timing control did not end one-shot");
    a_env_kill: assert property (@(posedge sys_clk) disable iff (rst)
        en_lvl |=> amp == '0 ##1 sound_sample == '0) // RULE16
        else $error("envelope not forced to zero");
    a_decay_ramp: assert property (@(posedge sys_clk) disable iff (rst)
        !gate && !$past(gate) && !en_lvl && !$past(en_lvl)
        |-> amp <= $past(amp)) // RULE17
        else $error("amplitude rose outside sound period");

    c_fire: cover property (@(posedge sys_clk) disable iff (rst)
        fire);
    c_abort: cover property (@(posedge sys_clk) disable iff (rst)
        oneshot_latched && en_lvl ##1 fall);
    c_expire: cover property (@(posedge sys_clk) disable iff (rst)
        expire);
    c_decay: cover property (@(posedge sys_clk) disable iff (rst)
        !gate && !en_lvl && amp != '0);
endmodule // sem_top

// >>> tb/sem_ctl_model.sv
`timescale 1ns/100ps
module sem_ctl_model (
    input  wire logic          sys_clk,
    output sem_pkg::sem_pins_s pins
);
    import sem_pkg::*;
    initial pins = '{1'b1, 1'b1, 3'h0, 3'h7, 1'b0};
    // -----------------------------------
    // Pin actions, launched after an edge
    // -----------------------------------
    task automatic drive_en(input logic lvl);
        @(posedge sys_clk);
        pins.en_n     <= lvl;
        pins.en_n_drv <= 1'b1;
    endtask
    // Released pad shows a changed level, the pull-down decides
    task automatic float_en();
        @(posedge sys_clk);
        pins.en_n     <= ~pins.en_n;
        pins.en_n_drv <= 1'b0;
    endtask
    task automatic rearm(input int hold_cyc);
        drive_en(1'b1);
        repeat (hold_cyc) @(posedge sys_clk);
        drive_en(1'b0);
    endtask
    task automatic select(input logic [2:0] sel, input logic [2:0] drv);
        @(posedge sys_clk);
        pins.mix     <= (sel & drv) | (~pins.mix & ~drv);
        pins.mix_drv <= drv;
    endtask
    // Outside multiplexer: equal halves on two select codes
    task automatic mux_toggle(input logic [2:0] a, input logic [2:0] b,
                              input int half_cyc, input int periods);
        repeat (periods) begin
            select(a, 3'b111);
            repeat (half_cyc - 1) @(posedge sys_clk);
            select(b, 3'b111);
            repeat (half_cyc - 1) @(posedge sys_clk);
        end
    endtask
    task automatic stop_pulse();
        @(posedge sys_clk);
        pins.os_stop <= 1'b1;
        @(posedge sys_clk);
        pins.os_stop <= 1'b0;
    endtask
endmodule // sem_ctl_model

// >>> tb/sound_enable_oneshot_mixer_test.sv
`timescale 1ns/100ps
`include "sem_defines.svh"
module sound_enable_oneshot_mixer_test;
    import sem_pkg::*;
    localparam int TICK   = 2;
    localparam int OS_CYC = 10 * `SEM_OS_NUM / `SEM_OS_DEN * TICK;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    sem_pins_s   pins;
    sem_tone_s   tones;
    logic [7:0]  sound_sample;
    logic        sound_active;
    logic        oneshot_latched;
    int          n_fail = 0;
    int          samples_checked = 0;

    always #5 sys_clk = ~sys_clk;

    sem_ctl_model i_ctl (.sys_clk(sys_clk), .pins(pins));
    sem_top #(.AMP_W(8), .RC_W(16), .TICK_CYC(TICK)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pins(pins), .tones(tones), .sound_sample(sound_sample),
        .sound_active(sound_active), .oneshot_latched(oneshot_latched));
    // -----------------------------------
    // Shared tasks
    // -----------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t %s: seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       input logic [3:0] be = 4'hf);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) check(1, 0, "bus answer missing");
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic wait_latch(input logic lvl, input int lim, output int n);
        n = 0;
        while (oneshot_latched !== lvl && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    function automatic logic mix_exp(input int s, input logic [2:0] t);
        case (s)
            0: return t[2];
            1: return t[1];
            2: return t[0];
            3: return t[2] & t[0];
            4: return t[1] & t[0];
            5: return &t;
            6: return t[1] & t[2];
            default: return 1'b0;
        endcase
    endfunction
    // -----------------------------------
    // Scenarios
    // -----------------------------------
    task automatic t_reset();
        logic [31:0] q;
        bus(0, `SEM_OFF_CTRL, 0, q);
        check(q, `SEM_CTRL_RST, "ctrl reset");
        bus(0, `SEM_OFF_OSRC, 0, q);
        check(q[15:0], `SEM_OSRC_RST, "osrc reset");
        bus(1, `SEM_OFF_OSRC, 32'h1234, q, 4'h1);
        bus(0, `SEM_OFF_OSRC, 0, q);
        check(q[15:0], (`SEM_OSRC_RST & 16'hff00) | 16'h0034,
              "osrc lane 0 only");
        bus(0, `SEM_OFF_RATE, 0, q);
        check(q[15:0], `SEM_RATE_RST, "rate reset");
        bus(1, 4'h2, 32'hffff, q);
        bus(0, 4'h2, 0, q);
        check(q, 0, "unmapped read");
        $display("test reset done");
    endtask
    task automatic t_mixer();
        logic [31:0] q;
        for (int s = 0; s < 8; s++) begin
            for (int t = 0; t < 8; t++) begin
                tones <= t[2:0];
                bus(1, `SEM_OFF_CTRL, {26'h0, s[2:0], 1'b1, 2'b00}, q);
                repeat (8) @(posedge sys_clk);
                bus(0, `SEM_OFF_STAT, 0, q);
                check(q[3], mix_exp(s, t[2:0]), "mixer bit");
            end
        end
        bus(1, `SEM_OFF_CTRL, 0, q);
        tones <= 3'b100;
        i_ctl.select(3'b111, 3'b000);
        repeat (8) @(posedge sys_clk);
        bus(0, `SEM_OFF_STAT, 0, q);
        check(q[3], 1, "open select pins");
        i_ctl.select(3'b111, 3'b111);
        repeat (8) @(posedge sys_clk);
        bus(0, `SEM_OFF_STAT, 0, q);
        check(q[3], 0, "inhibit via pins");
        $display("test mixer done");
    endtask
    task automatic t_cont();
        logic [31:0] q;
        bus(1, `SEM_OFF_RATE, 0, q);
        bus(1, `SEM_OFF_CTRL, 32'h7, q);
        tones <= 3'b100;
        i_ctl.drive_en(1'b0);
        repeat (40) @(posedge sys_clk);
        check(sound_active, 1, "continuous active");
        check(sound_sample != 0, 1, "sound passes");
        i_ctl.drive_en(1'b1);
        repeat (4) @(posedge sys_clk);
        check(sound_sample, 0, "enable high mutes");
        i_ctl.float_en();
        repeat (40) @(posedge sys_clk);
        check(sound_active, 1, "open enable sounds");
        i_ctl.drive_en(1'b1);
        $display("test continuous done");
    endtask
    task automatic t_mux();
        logic [31:0] q;
        int          hits;
        hits = 0;
        bus(1, `SEM_OFF_CTRL, 32'h2, q);
        tones <= 3'b100;
        i_ctl.drive_en(1'b0);
        repeat (20) @(posedge sys_clk);
        fork
            i_ctl.mux_toggle(3'b000, 3'b010, 1000, 2);
            repeat (4000) begin
                @(posedge sys_clk);
                if (sound_sample != 8'h0) hits++;
            end
        join
        check(hits >= 1990 && hits <= 2010, 1, "mux half duty");
        i_ctl.drive_en(1'b1);
        $display("test multiplex done");
    endtask
    task automatic t_oneshot();
        logic [31:0] q;
        int          n;
        int          hits;
        bus(1, `SEM_OFF_OSRC, 32'd10, q);
        bus(1, `SEM_OFF_CTRL, 32'h5, q);
        repeat (10) @(posedge sys_clk);
        i_ctl.drive_en(1'b0);
        wait_latch(1, 10, n);
        check(n <= 6, 1, "fire latency");
        wait_latch(0, 60, n);
        check(n >= OS_CYC - TICK && n <= OS_CYC + TICK + 2, 1,
              "one-shot length");
        repeat (2) @(posedge sys_clk);
        check(sound_active, 1, "decay after end");
        hits = 0;
        repeat (60) begin
            @(posedge sys_clk);
            if (oneshot_latched !== 1'b0) hits++;
        end
        check(hits, 0, "held low retrigger");
        $display("test one-shot done");
    endtask
    task automatic t_abort();
        int n;
        int hits;
        i_ctl.rearm(50 * TICK);
        wait_latch(1, 10, n);
        check(oneshot_latched, 1, "refire after pulse");
        repeat (3) @(posedge sys_clk);
        i_ctl.drive_en(1'b1);
        repeat (4) @(posedge sys_clk);
        check(sound_sample, 0, "abort mutes");
        check(oneshot_latched, 1, "latch kept");
        i_ctl.drive_en(1'b0);
        wait_latch(0, 60, n);
        hits = 0;
        repeat (30) begin
            @(posedge sys_clk);
            if (oneshot_latched !== 1'b0) hits++;
        end
        check(hits, 0, "early edge ignored");
        i_ctl.rearm(50 * TICK);
        wait_latch(1, 10, n);
        i_ctl.stop_pulse();
        wait_latch(0, 8, n);
        check(oneshot_latched, 0, "timing stop ends");
        $display("test abort and stop done");
    endtask
    // -----------------------------------
    // Sequence and verdict
    // -----------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        avs_address    <= 4'h0;
        avs_read       <= 1'b0;
        avs_write      <= 1'b0;
        avs_writedata  <= 32'h0;
        avs_byteenable <= 4'h0;
        tones          <= 3'h0;
        repeat (16) @(posedge sys_clk);
        check(avs_waitrequest, 1, "reset waitrequest");
        check(sound_sample, 0, "reset sample");
        check(oneshot_latched, 0, "reset latch");
        rst <= 1'b0;
        t_reset();
        t_mixer();
        t_cont();
        t_mux();
        t_oneshot();
        t_abort();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule // sound_enable_oneshot_mixer_test
